// ==== tla_pkg.sv ====
// Constants and helper functions of the thermal limit alert block.
//
// Contract
// R1: Hysteresis code selects zero, 1.5, 3, 6 degrees.
// R2: Below flag sets under lower-hyst, clears at lower.
// R3: Above flag sets over upper, clears at upper-hyst.
// R4: Critical alert holds until critical minus hysteresis.
// R5: Sleep bit stops conversions, events and data updates.
// R6: Locks reject setting sleep; clearing always accepted.
// R7: Register access works normally while asleep.
// R8: Critical freeze locks critical limit until power-on.
// R9: Window freeze locks upper/lower limits until power-on.
// R10: Release bit clears latched alert, interrupt mode only.
// R11: Alert state bit reflects asserted alert output.
// R12: Alert enable gates output; locked by either freeze.
// R13: Critical-only bit limits alerts; window freeze locks it.
// R14: Polarity bit chooses asserted pin level.
// R15: Mode bit: comparator zero, interrupt one (reset).
// R16: Temperatures two's complement, sign bit 12, sixteenth-degree steps.
// R17: Comparisons use bits 12 to 2; reads keep fine bits. The code masks read bits to RESOLUTION_CODE_IN.
// R18: Host zeroes limit bit 2 at half-degree resolution.
// R19: Host writes zero into unused limit bits.
// R20: Hysteresis code frozen while either lock set.
// R21: Data register bits 15-13 show critical, above, below.
// R22: Comparisons and alert update once per conversion.
package tla_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_CFG = 8'h01;
  localparam logic [7:0] ADDR_UPPER = 8'h02;
  localparam logic [7:0] ADDR_LOWER = 8'h03;
  localparam logic [7:0] ADDR_CRIT = 8'h04;
  localparam logic [7:0] ADDR_TEMP = 8'h05;

  localparam logic [15:0] CFG_RESET = 16'h0001;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;

  localparam int unsigned CFG_MODE_BIT = 0;
  localparam int unsigned CFG_POL_BIT = 1;
  localparam int unsigned CFG_CONLY_BIT = 2;
  localparam int unsigned CFG_EN_BIT = 3;
  localparam int unsigned CFG_STATE_BIT = 4;
  localparam int unsigned CFG_REL_BIT = 5;
  localparam int unsigned CFG_WLOCK_BIT = 6;
  localparam int unsigned CFG_CLOCK_BIT = 7;
  localparam int unsigned CFG_SLEEP_BIT = 8;
  localparam int unsigned CFG_HYST_LSB = 9;

  localparam logic [1:0] HYST_OFF = 2'h0;
  localparam logic [1:0] HYST_1P5 = 2'h1;
  localparam logic [1:0] HYST_3 = 2'h2;
  localparam logic signed [11:0] HYST_Q_1P5 = 12'sh006;
  localparam logic signed [11:0] HYST_Q_3 = 12'sh00C;
  localparam logic signed [11:0] HYST_Q_6 = 12'sh018;

  // Hysteresis in quarter-degree steps, the unit of the comparators.
  function automatic logic signed [11:0] hyst_qtr(input logic [1:0] code);
    logic signed [11:0] q;
    q = 12'sh000;
    unique case (code)
      HYST_OFF: q = 12'sh000;
      HYST_1P5: q = HYST_Q_1P5;
      HYST_3: q = HYST_Q_3;
      default: q = HYST_Q_6;
    endcase
    return q;
  endfunction

  // Bits 12 to 2 as a signed quarter-degree value; finer bits are dropped.
  function automatic logic signed [11:0] to_qtr(input logic [12:0] v);
    return $signed({v[12], v[12:2]});
  endfunction

  // Keeps only the fractional bits that the resolution code supports.
  function automatic logic [12:0] res_mask(input logic [1:0] code);
    logic [12:0] m;
    m = 13'h1FF8;
    unique case (code)
      2'h0: m = 13'h1FF8;
      2'h1: m = 13'h1FFC;
      2'h2: m = 13'h1FFE;
      default: m = 13'h1FFF;
    endcase
    return m;
  endfunction

endpackage

// ==== tla_sync.sv ====
// Two-flop level synchroniser into the receiving clock domain.
`timescale 1ns/100ps
module tla_sync #(
  parameter int unsigned DEPTH = 2
) (
  // Receiving domain.
  input wire logic clk_in,
  input wire logic rst_in,
  // Level from the other domain and its synchronised copy.
  input wire logic d_in,
  output logic q_out
);

  typedef struct packed {
    logic [DEPTH-1:0] sh;
  } tla_sync_st_t;

  tla_sync_st_t s_r;
  tla_sync_st_t s_nxt;

  if (DEPTH < 2) begin : g_chk
    $error("tla_sync needs at least two stages");
  end

  // The first stage feeds only the next stage, never any logic.
  always_comb begin
    s_nxt = s_r;
    s_nxt.sh = {s_r.sh[DEPTH-2:0], d_in};
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_out = s_r.sh[DEPTH-1];

endmodule

// ==== tla_alert.sv ====
// Thermal limit comparators, alert pin logic and register file.
`timescale 1ns/100ps
module tla_alert
  import tla_pkg::*;
#(
  parameter int unsigned SYNC_DEPTH = 2
) (
  // Core clock and power-on reset.
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // Register port from the bus engine, on the link clock.
  input wire logic LINK_CLK_IN,
  input wire logic REG_REQ_IN,
  input wire logic REG_WR_IN,
  input wire logic [ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [15:0] REG_WDATA_IN,
  output logic REG_BUSY_OUT,
  output logic REG_DONE_OUT,
  output logic [15:0] REG_RDATA_OUT,
  // Converter results and control, on the core clock.
  input wire logic CONV_VALID_IN,
  input wire logic [12:0] CONV_TEMP_IN,
  input wire logic [1:0] RESOLUTION_CODE_IN,
  output logic CONV_RUN_OUT,
  // Open-drain alert pin.
  output logic ALERT_OUT,
  output logic ALERT_OE_OUT
);

  if (SYNC_DEPTH < 2) begin : g_chk
    $error("tla_alert needs at least two synchroniser stages");
  end

  typedef struct packed {
    logic busy;
    logic done;
    logic req_tgl;
    logic ack_seen;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
  } tla_link_st_t;

  typedef struct packed {
    logic [1:0] hyst;
    logic sleep_control;
    logic crit_limit_freeze;
    logic win_limit_freeze;
    logic alert_en;
    logic crit_only_alerts;
    logic alert_polarity;
    logic alert_mode;
    logic [15:0] upper_trip_point;
    logic [15:0] lower_trip_point;
    logic [15:0] critical_trip_point;
    logic [12:0] temp;
    logic st_crit;
    logic st_above;
    logic st_below;
    logic latch;
    logic alert_state;
    logic pin_oe;
    logic pin_lvl;
    logic run;
    logic req_seen;
    logic ack_tgl;
    logic [15:0] rdata;
  } tla_core_st_t;

  tla_link_st_t lk_r;
  tla_link_st_t lk_nxt;
  tla_core_st_t c_r;
  tla_core_st_t c_nxt;
  logic req_sync;
  logic ack_sync;

  // Request toggle into the core domain.
  tla_sync #(
    .DEPTH(SYNC_DEPTH)
  ) u_req_sync (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .d_in(lk_r.req_tgl),
    .q_out(req_sync)
  );

  // Acknowledge toggle back into the link domain.
  tla_sync #(
    .DEPTH(SYNC_DEPTH)
  ) u_ack_sync (
    .clk_in(LINK_CLK_IN),
    .rst_in(RST_IN),
    .d_in(c_r.ack_tgl),
    .q_out(ack_sync)
  );

  // Link side: one access in flight. Address and data stay frozen while busy,
  // so the core may sample them once the toggle has crossed.
  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.done = 1'b0;
    if (!lk_r.busy) begin
      if (REG_REQ_IN) begin
        lk_nxt.busy = 1'b1;
        lk_nxt.req_tgl = ~lk_r.req_tgl;
        lk_nxt.wr = REG_WR_IN;
        lk_nxt.addr = REG_ADDR_IN;
        lk_nxt.wdata = REG_WDATA_IN;
      end
    end else if (ack_sync != lk_r.ack_seen) begin
      // The core holds its answer word until the next request, so it is stable here.
      lk_nxt.ack_seen = ack_sync;
      lk_nxt.rdata = c_r.rdata;
      lk_nxt.done = 1'b1;
      lk_nxt.busy = 1'b0;
    end
  end

  always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // Core side: register access, comparators and alert pin.
  always_comb begin
    logic [15:0] wd;
    logic [15:0] rd;
    logic any_lock;
    logic release_req;
    logic evt;
    logic window;
    logic signed [11:0] t;
    logic signed [11:0] h;
    logic signed [11:0] qu;
    logic signed [11:0] ql;
    logic signed [11:0] qc;
    wd = lk_r.wdata;
    rd = 16'h0000;
    any_lock = c_r.crit_limit_freeze | c_r.win_limit_freeze;
    release_req = 1'b0;
    evt = 1'b0;
    window = 1'b0;
    t = to_qtr(CONV_TEMP_IN);
    h = hyst_qtr(c_r.hyst); // R1
    qu = to_qtr(c_r.upper_trip_point[12:0]);
    ql = to_qtr(c_r.lower_trip_point[12:0]);
    qc = to_qtr(c_r.critical_trip_point[12:0]);
    c_nxt = c_r;

    // Accesses are served whatever the sleep state. R7
    if (req_sync != c_r.req_seen) begin
      c_nxt.req_seen = req_sync;
      c_nxt.ack_tgl = ~c_r.ack_tgl;
      unique case (lk_r.addr)
        ADDR_CFG: begin
          rd[CFG_HYST_LSB +: 2] = c_r.hyst;
          rd[CFG_SLEEP_BIT] = c_r.sleep_control;
          rd[CFG_CLOCK_BIT] = c_r.crit_limit_freeze;
          rd[CFG_WLOCK_BIT] = c_r.win_limit_freeze;
          rd[CFG_STATE_BIT] = c_r.alert_state; // R11
          rd[CFG_EN_BIT] = c_r.alert_en;
          rd[CFG_CONLY_BIT] = c_r.crit_only_alerts;
          rd[CFG_POL_BIT] = c_r.alert_polarity;
          rd[CFG_MODE_BIT] = c_r.alert_mode;
        end
        ADDR_UPPER: rd = c_r.upper_trip_point;
        ADDR_LOWER: rd = c_r.lower_trip_point;
        ADDR_CRIT: rd = c_r.critical_trip_point;
        ADDR_TEMP: begin
          rd = {c_r.st_crit, c_r.st_above, c_r.st_below, 13'h0000}; // R21
          rd[12:0] = c_r.temp & res_mask(RESOLUTION_CODE_IN); // R17
        end
        default: rd = 16'h0000;
      endcase
      c_nxt.rdata = lk_r.wr ? 16'h0000 : rd;
      if (lk_r.wr) begin
        unique case (lk_r.addr)
          ADDR_CFG: begin
            if (!any_lock) begin
              c_nxt.hyst = wd[CFG_HYST_LSB +: 2]; // R20
              c_nxt.alert_en = wd[CFG_EN_BIT]; // R12
            end
            if (!wd[CFG_SLEEP_BIT]) begin
              c_nxt.sleep_control = 1'b0; // R6
            end else if (!any_lock) begin
              c_nxt.sleep_control = 1'b1; // R6
            end
            // Freeze bits are set-only; only reset clears them.
            c_nxt.crit_limit_freeze = c_r.crit_limit_freeze | wd[CFG_CLOCK_BIT]; // R8
            c_nxt.win_limit_freeze = c_r.win_limit_freeze | wd[CFG_WLOCK_BIT]; // R9
            if (!c_r.win_limit_freeze) begin
              c_nxt.crit_only_alerts = wd[CFG_CONLY_BIT]; // R13
            end
            c_nxt.alert_polarity = wd[CFG_POL_BIT]; // R14
            c_nxt.alert_mode = wd[CFG_MODE_BIT]; // R15
            // The release bit is a strobe and is never stored.
            release_req = wd[CFG_REL_BIT] & c_r.alert_mode; // R10
          end
          ADDR_UPPER: begin
            if (!c_r.win_limit_freeze) begin
              c_nxt.upper_trip_point = wd; // R9
            end
          end
          ADDR_LOWER: begin
            if (!c_r.win_limit_freeze) begin
              c_nxt.lower_trip_point = wd; // R9
            end
          end
          ADDR_CRIT: begin
            if (!c_r.crit_limit_freeze) begin
              c_nxt.critical_trip_point = wd; // R8
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Results are ignored while asleep, so flags and data stay frozen.
    if (CONV_VALID_IN && !c_r.sleep_control) begin // R5 R22
      c_nxt.temp = CONV_TEMP_IN; // R16
      if (t > qc) begin
        c_nxt.st_crit = 1'b1; // R4
      end else if (t <= qc - h) begin
        c_nxt.st_crit = 1'b0; // R4
      end
      if (t > qu) begin
        c_nxt.st_above = 1'b1; // R3
      end else if (t <= qu - h) begin
        c_nxt.st_above = 1'b0; // R3
      end
      if (t < ql - h) begin
        c_nxt.st_below = 1'b1; // R2
      end else if (t >= ql) begin
        c_nxt.st_below = 1'b0; // R2
      end
      // Window crossings in either direction are events; the critical flag
      // is one only when it rises, since it keeps the pin asserted anyway.
      window = (c_nxt.st_above != c_r.st_above) | (c_nxt.st_below != c_r.st_below);
      evt = c_r.alert_en & ((c_nxt.st_crit & ~c_r.st_crit)
            | (~c_r.crit_only_alerts & window)); // R13
    end

    // A new event in the release cycle wins, so it is never lost.
    if (!c_nxt.alert_mode) begin
      c_nxt.latch = 1'b0;
    end else if (evt) begin
      c_nxt.latch = 1'b1; // R22
    end else if (release_req) begin
      c_nxt.latch = 1'b0; // R10
    end

    if (!c_nxt.alert_en) begin
      c_nxt.alert_state = 1'b0; // R12
    end else if (c_nxt.alert_mode) begin
      c_nxt.alert_state = c_nxt.latch | c_nxt.st_crit; // R4 R15
    end else begin
      c_nxt.alert_state = c_nxt.st_crit
        | (~c_nxt.crit_only_alerts & (c_nxt.st_above | c_nxt.st_below)); // R13 R15
    end

    // Open drain: the pin is pulled low whenever its level must be zero.
    c_nxt.pin_oe = c_nxt.alert_state ^ c_nxt.alert_polarity; // R14
    c_nxt.pin_lvl = 1'b0;
    c_nxt.run = ~c_nxt.sleep_control; // R5
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      c_r <= '0;
      c_r.alert_mode <= CFG_RESET[CFG_MODE_BIT]; // R15
      c_r.upper_trip_point <= LIMIT_RESET;
      c_r.lower_trip_point <= LIMIT_RESET;
      c_r.critical_trip_point <= LIMIT_RESET;
      c_r.run <= 1'b1;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign REG_BUSY_OUT = lk_r.busy;
  assign REG_DONE_OUT = lk_r.done;
  assign REG_RDATA_OUT = lk_r.rdata;
  assign CONV_RUN_OUT = c_r.run;
  assign ALERT_OUT = c_r.pin_lvl;
  assign ALERT_OE_OUT = c_r.pin_oe;

endmodule

// ==== tla_alert_sva.sv ====
// Port-level assertions of the thermal limit alert block.
`timescale 1ns/100ps
module tla_alert_sva (
  // Clocks and reset.
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic LINK_CLK_IN,
  // Register port.
  input wire logic REG_REQ_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_BUSY_OUT,
  input wire logic REG_DONE_OUT,
  input wire logic [15:0] REG_RDATA_OUT,
  // Converter and pin.
  input wire logic CONV_VALID_IN,
  input wire logic CONV_RUN_OUT,
  input wire logic ALERT_OUT,
  input wire logic ALERT_OE_OUT
);
  logic wr_r;
  // A write answers zero, so the kind of the access in flight is kept.
  always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      wr_r <= 1'b0;
    end else if (REG_REQ_IN && !REG_BUSY_OUT) begin
      wr_r <= REG_WR_IN;
    end
  end
  a_take_busy: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
    REG_REQ_IN && !REG_BUSY_OUT |=> REG_BUSY_OUT) else $error("request not taken");
  a_busy_bound: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
    $rose(REG_BUSY_OUT) |-> ##[1:40] REG_DONE_OUT) else $error("access never done");
  a_done_pulse: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
    REG_DONE_OUT |=> !REG_DONE_OUT) else $error("done longer than one cycle");
  a_done_idle: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
    REG_DONE_OUT |-> !REG_BUSY_OUT && $past(REG_BUSY_OUT)) else $error("done without busy");
  a_wr_zero: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
    REG_DONE_OUT && wr_r |-> REG_RDATA_OUT == 16'h0000) else $error("write data not zero");
  a_rdata_hold: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
    !REG_DONE_OUT |-> $stable(REG_RDATA_OUT)) else $error("read data moved");
  a_oe_cause: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    $changed(ALERT_OE_OUT) |-> $past(CONV_VALID_IN) || $past(REG_BUSY_OUT)
    || $past(REG_BUSY_OUT, 2)) else $error("pin moved without cause");
  a_run_cause: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    $changed(CONV_RUN_OUT) |-> REG_BUSY_OUT || $past(REG_BUSY_OUT)
    || $past(REG_BUSY_OUT, 2)) else $error("run moved without write");
  a_pin_low: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    ALERT_OUT == 1'b0) else $error("pin driven high");
  c_wr_done: cover property (@(posedge LINK_CLK_IN) REG_DONE_OUT && wr_r);
  c_oe_rise: cover property (@(posedge REF_CLK_IN) $rose(ALERT_OE_OUT));
  c_sleep: cover property (@(posedge REF_CLK_IN) $fell(CONV_RUN_OUT));
endmodule
bind tla_alert tla_alert_sva tla_alert_sva_i (.REF_CLK_IN, .RST_IN, .LINK_CLK_IN, .REG_REQ_IN,
  .REG_WR_IN, .REG_BUSY_OUT, .REG_DONE_OUT, .REG_RDATA_OUT, .CONV_VALID_IN, .CONV_RUN_OUT,
  .ALERT_OUT, .ALERT_OE_OUT);

// ==== tla_host.sv ====
// Host model issuing register accesses on the link clock.
`timescale 1ns/100ps
module tla_host (
  // Link clock and answers.
  input wire logic clk_in,
  input wire logic busy_in,
  input wire logic done_in,
  input wire logic [15:0] rdata_in,
  // Request lines.
  output logic req_out,
  output logic wr_out,
  output logic [7:0] addr_out,
  output logic [15:0] wdata_out
);
  initial begin
    req_out = 1'b0;
    wr_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 16'h0000;
  end
  // Released lines show the inverse, so a late sample never reads stale data.
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input int gap, output logic [15:0] q);
    int n;
    n = 0;
    q = 16'hXXXX;
    repeat (gap + 1) @(negedge clk_in);
    req_out = 1'b1;
    wr_out = w;
    addr_out = a;
    wdata_out = d;
    // Busy is looked at off the sampling edge, so the taking edge is never misread.
    do begin
      @(negedge clk_in);
      n++;
    end while (busy_in !== 1'b1 && n < 40);
    n = 0;
    req_out = 1'b0;
    wr_out = ~w;
    addr_out = ~a;
    wdata_out = ~d;
    while (done_in !== 1'b1 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    if (n < 40) begin
      q = rdata_in;
    end
  endtask
endmodule

// ==== tla_alert_tb.sv ====
// Self-checking bench of the thermal limit alert block.
`timescale 1ns/100ps
module tla_alert_tb;
  import tla_pkg::*;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic valid = 1'b0;
  logic [12:0] temp = 13'h0000;
  logic [1:0] res = 2'h1;
  logic req, wr, busy, done, run, aout, oe;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, q;
  logic [12:0] hq [4] = '{13'h0000, 13'h0018, 13'h0030, 13'h0060};
  int errors = 0;
  int n_compared = 0;
  wire pin = oe ? aout : 1'b1;
  always #50 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  tla_alert tla_alert_i (.REF_CLK_IN(ref_clk), .RST_IN(rst), .LINK_CLK_IN(link_clk),
    .REG_REQ_IN(req), .REG_WR_IN(wr), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_BUSY_OUT(busy), .REG_DONE_OUT(done), .REG_RDATA_OUT(rdata),
    .CONV_VALID_IN(valid), .CONV_TEMP_IN(temp), .RESOLUTION_CODE_IN(res),
    .CONV_RUN_OUT(run), .ALERT_OUT(aout), .ALERT_OE_OUT(oe));
  tla_host tla_host_i (.clk_in(link_clk), .busy_in(busy), .done_in(done), .rdata_in(rdata),
    .req_out(req), .wr_out(wr), .addr_out(addr), .wdata_out(wdata));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    tla_host_i.acc(1'b1, a, d, 2, q);
    chk("write answer", 16'h0000, q);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    tla_host_i.acc(1'b0, a, 16'h0000, 0, q);
    chk($sformatf("register %h", a), e, q);
  endtask
  task automatic pin_is(input logic e);
    @(negedge ref_clk);
    chk("alert pin", {15'h0000, e}, {15'h0000, pin});
  endtask
  task automatic conv(input logic [12:0] t, input logic e);
    @(negedge ref_clk);
    valid = 1'b1;
    temp = t;
    @(negedge ref_clk);
    valid = 1'b0;
    chk("alert pin", {15'h0000, e}, {15'h0000, pin});
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Thirty-eight accesses of under a microsecond each; a hang is cut well beyond that.
  initial begin
    #3000000;
    errors++;
    results();
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    rd_reg(ADDR_CFG, CFG_RESET);
    for (int a = 2; a < 5; a++) rd_reg(8'(a), LIMIT_RESET);
    rd_reg(8'h09, 16'h0000);
    pin_is(1'b1);
    wr_reg(ADDR_UPPER, 16'h01E0);
    wr_reg(ADDR_LOWER, 16'h1FC0);
    wr_reg(ADDR_CRIT, 16'h0320);
    $display("test reset done");
    for (int h = 0; h < 4; h++) begin
      wr_reg(ADDR_CFG, {5'h00, 2'(h), 9'h008});
      conv(13'h01F0, 1'b0);
      rd_reg(ADDR_TEMP, 16'h41F0);
      conv(13'h01E4 - hq[h], 1'b0);
      conv(13'h01E0 - hq[h], 1'b1);
    end
    conv(13'h1F5C, 1'b0);
    rd_reg(ADDR_TEMP, 16'h3F5C);
    conv(13'h1FBC, 1'b0);
    conv(13'h1FC0, 1'b1);
    res = 2'h3;
    conv(13'h01E3, 1'b1);
    rd_reg(ADDR_TEMP, 16'h01E3);
    res = 2'h0;
    rd_reg(ADDR_TEMP, 16'h01E0);
    res = 2'h1;
    $display("test window done");
    wr_reg(ADDR_CFG, 16'h020C);
    conv(13'h01F0, 1'b1);
    conv(13'h0324, 1'b0);
    rd_reg(ADDR_TEMP, 16'hC324);
    conv(13'h030C, 1'b0);
    conv(13'h0308, 1'b1);
    wr_reg(ADDR_CFG, 16'h0009);
    pin_is(1'b1);
    conv(13'h0100, 1'b0);
    rd_reg(ADDR_CFG, 16'h0019);
    conv(13'h0110, 1'b0);
    wr_reg(ADDR_CFG, 16'h0029);
    pin_is(1'b1);
    rd_reg(ADDR_CFG, 16'h0009);
    conv(13'h01F0, 1'b0);
    wr_reg(ADDR_CFG, 16'h000B);
    pin_is(1'b1);
    wr_reg(ADDR_CFG, 16'h002B);
    pin_is(1'b0);
    wr_reg(ADDR_CFG, 16'h0000);
    pin_is(1'b1);
    conv(13'h0100, 1'b1);
    $display("test alert done");
    wr_reg(ADDR_CFG, 16'h01C8);
    chk("run", 16'h0000, {15'h0000, run});
    conv(13'h01F0, 1'b1);
    rd_reg(ADDR_TEMP, 16'h0100);
    wr_reg(ADDR_UPPER, 16'h0100);
    wr_reg(ADDR_CRIT, 16'h0000);
    rd_reg(ADDR_UPPER, 16'h01E0);
    rd_reg(ADDR_CRIT, 16'h0320);
    wr_reg(ADDR_CFG, 16'h06C6);
    rd_reg(ADDR_CFG, 16'h00CA);
    wr_reg(ADDR_CFG, 16'h0100);
    rd_reg(ADDR_CFG, 16'h00C8);
    chk("run", 16'h0001, {15'h0000, run});
    $display("test lock done");
    results();
  end
endmodule
